// ---- inc/pgee_consts.svh ----
// How it works
// - write strobe: WE low pulse, OE high
// - next byte within 150 us
// - upper address same across a page
// - three-byte guard enable sequence
// - guarded writes need the prefix
// - command bytes follow page timing
`ifndef PGEE_CONSTS_SVH
`define PGEE_CONSTS_SVH
`define PGEE_CLK_NS        40
`define PGEE_BLC_US        150
`define PGEE_BLC_CYC       ((`PGEE_BLC_US * 1000) / `PGEE_CLK_NS)
`define PGEE_BLC_SAFE_CYC  (`PGEE_BLC_CYC / 2)
`define PGEE_WC_MS         10
`define PGEE_WC_CYC        ((`PGEE_WC_MS * 1000000) / `PGEE_CLK_NS)
`define PGEE_PON_MS        5
`define PGEE_PON_CYC       ((`PGEE_PON_MS * 1000000) / `PGEE_CLK_NS)
`define PGEE_PULSE_NS      120
`define PGEE_PULSE_CYC     ((`PGEE_PULSE_NS + `PGEE_CLK_NS - 1) / `PGEE_CLK_NS)
`define PGEE_PAGE_BYTES    128
`define PGEE_ID_BASE       17'h1FF80
`define PGEE_CMD_A0        17'h05555
`define PGEE_CMD_A1        17'h02AAA
`define PGEE_CMD_A2        17'h05555
`define PGEE_CMD_D0        8'hAA
`define PGEE_CMD_D1        8'h55
`define PGEE_CMD_EN        8'hA0
`define PGEE_CMD_DIS       8'h20
`define PGEE_POLL_BIT      7
`define PGEE_FLIP_BIT      6
`endif

// ---- inc/pgee_pkg.sv ----
package pgee_pkg;
  // host request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        last;
    logic        id_area;
    logic [16:0] addr;
    logic [7:0]  data;
  } pgee_req_t;
  // host answer
  typedef struct packed {
    logic       done;
    logic       timeout;
    logic [7:0] data;
  } pgee_rsp_t;
  // pin bundle driven to the memory
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        id_hv;
    logic [16:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } pgee_pins_t;
  typedef enum logic [2:0] {
    PGEE_PWRUP = 3'b000,
    PGEE_IDLE  = 3'b001,
    PGEE_STRB  = 3'b011,
    PGEE_GAP   = 3'b010,
    PGEE_RD    = 3'b110,
    PGEE_POLL  = 3'b111,
    PGEE_CHK   = 3'b101
  } pgee_state_t;
endpackage

// ---- src/pgee_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// down counter with load and zero flag
module pgee_timer
  import pgee_pkg::*;
#(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         RST,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // status
  output logic              zero
);
  logic [W-1:0] count;  // remaining cycles
  // load wins, otherwise count to zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end
  assign zero = (count == '0);
endmodule
`default_nettype wire

// ---- src/pgee_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pgee_consts.svh"
// host controller driving the paged memory pins
module pgee_host
  import pgee_pkg::*;
#(
  parameter int          PON_CYC  = `PGEE_PON_CYC,
  parameter int          WC_CYC   = `PGEE_WC_CYC,
  parameter int          GAP_CYC  = `PGEE_BLC_SAFE_CYC,
  parameter int          PLS_CYC  = `PGEE_PULSE_CYC,
  parameter logic [16:0] CMD_A0   = `PGEE_CMD_A0,
  parameter logic [16:0] CMD_A1   = `PGEE_CMD_A1,
  parameter logic [16:0] CMD_A2   = `PGEE_CMD_A2,
  parameter logic [7:0]  CMD_D0   = `PGEE_CMD_D0,
  parameter logic [7:0]  CMD_D1   = `PGEE_CMD_D1,
  parameter logic [7:0]  CMD_EN   = `PGEE_CMD_EN,
  parameter logic [7:0]  CMD_DIS  = `PGEE_CMD_DIS
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // user request
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_LAST,
  input  wire logic        REQ_ID,
  input  wire logic [16:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_DATA,
  input  wire logic        GUARD_PREFIX,
  input  wire logic        GUARD_DISABLE,
  output logic             REQ_READY,
  // user answer
  output logic             RSP_DONE,
  output logic             RSP_TIMEOUT,
  output logic [7:0]       RSP_DATA,
  // memory pins
  output logic             MEM_CE_N,
  output logic             MEM_OE_N,
  output logic             MEM_WE_N,
  output logic             MEM_ID_HV,
  output logic [16:0]      MEM_ADDR,
  output logic [7:0]       MEM_DQ_OUT,
  output logic             MEM_DQ_OE,
  input  wire logic [7:0]  MEM_DQ_IN
);
  localparam int TW = 24;
  // refuse timing the sequencer cannot serve
  if (PLS_CYC < 3 || PLS_CYC > 250 || GAP_CYC < 2 || GAP_CYC >= `PGEE_BLC_CYC ||
      WC_CYC >= (1 << TW) || PON_CYC >= (1 << TW)) begin : g_bad_timing
    $error("pgee_host: timing parameter out of range");
  end
  // complete state
  typedef struct packed {
    pgee_state_t st;
    pgee_pins_t  pin;
    logic [7:0]  ph;
    logic [1:0]  pre;
    logic [7:0]  cnt;
    logic        first;
    logic        in_page;
    logic        last_w;
    logic [9:0]  page;
    logic [7:0]  wdat;
    logic [7:0]  prevp;
    logic        rdy;
    pgee_rsp_t   rsp;
    pgee_req_t   hold;
  } pgee_core_t;
  pgee_core_t s;       // registered state
  pgee_core_t next_s;  // next state
  logic       t_load;  // timer reload
  logic [TW-1:0] t_val;
  logic       t_zero;
  // shared delay timer
  pgee_timer #(.W(TW)) u_tmr (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .load     (t_load),
    .value    (t_val),
    .zero     (t_zero)
  );
  // sequencing of pins
  always_comb begin
    next_s = s;
    t_load = 1'b0;
    t_val  = '0;
    next_s.rsp.done    = 1'b0;
    next_s.rsp.timeout = 1'b0;
    next_s.rdy         = 1'b0;
    unique case (s.st)
      PGEE_PWRUP: begin
        if (s.first) begin
          t_load = 1'b1;
          t_val  = TW'(PON_CYC);
          next_s.first = 1'b0;
        end else if (t_zero) begin
          next_s.st  = PGEE_IDLE;
          next_s.rdy = 1'b1;
        end
      end
      PGEE_IDLE: begin
        next_s.rdy = 1'b1;
        if (s.in_page && t_zero) begin
          next_s.in_page = 1'b0;
          next_s.first   = 1'b1;  // first poll has no earlier read to compare
          next_s.st  = PGEE_POLL;
          next_s.rdy = 1'b0;
          t_load = 1'b1;
          t_val  = TW'(WC_CYC);
        end else if (REQ_VALID && s.rdy) begin
          next_s.rdy  = 1'b0;
          next_s.hold = '{1'b1, REQ_WRITE, REQ_LAST, REQ_ID, REQ_ADDR, REQ_DATA};
          next_s.pin.id_hv = REQ_ID;
          if (REQ_WRITE) begin
            // prefix or disable sequence before first byte of a page
            next_s.pre = (!s.in_page && (GUARD_PREFIX || GUARD_DISABLE)) ? 2'h0 : 2'h3;
            next_s.cnt = GUARD_DISABLE ? 8'h06 : 8'h03;
            next_s.st  = PGEE_STRB;
            next_s.ph  = 8'h00;
          end else begin
            next_s.st  = PGEE_RD;
            next_s.ph  = 8'h00;
          end
        end
      end
      PGEE_STRB: begin
        // choose the byte of this strobe
        next_s.ph = s.ph + 8'h01;
        if (s.ph == 8'h00) begin
          next_s.pin.oe_n  = 1'b1;
          next_s.pin.dq_oe = 1'b1;
          if (s.pre != 2'h3) begin
            next_s.pin.addr   = (s.cnt[0] ^ (s.pre == 2'h1)) ? CMD_A1 : CMD_A0;
            next_s.pin.addr   = (s.pre == 2'h2) ? CMD_A2 : next_s.pin.addr;
            next_s.pin.dq_out = (s.pre == 2'h0) ? CMD_D0 :
                                (s.pre == 2'h1) ? CMD_D1 :
                                (s.cnt == 8'h06) ? CMD_DIS : CMD_EN;
            next_s.pin.addr   = (s.pre == 2'h1) ? CMD_A1 : next_s.pin.addr;
            next_s.pin.addr   = (s.pre == 2'h0) ? CMD_A0 : next_s.pin.addr;
          end else begin
            next_s.pin.addr   = s.hold.id_area ? (`PGEE_ID_BASE | {10'h000, s.hold.addr[6:0]})
                                               : s.hold.addr;
            next_s.pin.dq_out = s.hold.data;
            next_s.page       = next_s.pin.addr[16:7];
            next_s.wdat       = s.hold.data;
          end
        end else if (s.ph == 8'h01) begin
          next_s.pin.ce_n = 1'b0;
          next_s.pin.we_n = 1'b0;
        end else if (s.ph == 8'(PLS_CYC + 1)) begin
          next_s.pin.we_n = 1'b1;
          next_s.pin.ce_n = 1'b1;
        end else if (s.ph == 8'(PLS_CYC + 2)) begin
          next_s.pin.dq_oe = 1'b0;
          next_s.st = PGEE_GAP;
        end
      end
      PGEE_GAP: begin
        // load timeout restarts on every byte except the last, which loads the write cycle timeout
        t_load = 1'b1;
        t_val  = TW'(GAP_CYC);
        next_s.in_page = 1'b1;
        if (s.pre != 2'h3 && !(s.pre == 2'h2 && s.cnt == 8'h06)) begin
          next_s.pre = s.pre + 2'h1;
          next_s.st  = PGEE_STRB;
          next_s.ph  = 8'h00;
        end else if (s.pre == 2'h2 && s.cnt == 8'h06) begin
          next_s.pre = 2'h3;
          next_s.st  = PGEE_IDLE;
          next_s.rsp.done = 1'b1;  // disable sequence holds no data
          next_s.hold.last = 1'b1;
          next_s.last_w = 1'b0;
        end else begin
          next_s.st = PGEE_IDLE;
          next_s.rsp.done = 1'b1;
          next_s.last_w = 1'b1;
          next_s.in_page = ~s.hold.last;
        end
        if (s.pre == 2'h3 && s.hold.last) begin
          next_s.st  = PGEE_POLL;
          next_s.in_page = 1'b0;
          t_val = TW'(WC_CYC);
          next_s.first = 1'b1;  // first poll has no earlier read to compare
        end
      end
      PGEE_RD: begin
        next_s.ph = s.ph + 8'h01;
        if (s.ph == 8'h00) begin
          next_s.pin.addr = s.hold.id_area ? (`PGEE_ID_BASE | {10'h000, s.hold.addr[6:0]})
                                           : s.hold.addr;
          next_s.pin.dq_oe = 1'b0;
        end else if (s.ph == 8'h01) begin
          next_s.pin.ce_n = 1'b0;
          next_s.pin.oe_n = 1'b0;
        end else if (s.ph == 8'(PLS_CYC + 1)) begin
          next_s.rsp.data = MEM_DQ_IN;
          next_s.pin.ce_n = 1'b1;
          next_s.pin.oe_n = 1'b1;
          if (s.st == PGEE_RD && s.hold.valid && !s.hold.write) begin
            next_s.rsp.done = 1'b1;
            next_s.hold.valid = 1'b0;
            next_s.st = (s.in_page) ? PGEE_IDLE : PGEE_IDLE;
          end
        end
      end
      PGEE_POLL: begin
        // read last byte until poll and flip bits settle
        next_s.ph = s.ph + 8'h01;
        if (s.ph == 8'h00) begin
          next_s.pin.addr = {s.page, s.hold.id_area ? s.hold.addr[6:0] : s.pin.addr[6:0]};
          next_s.pin.dq_oe = 1'b0;
        end else if (s.ph == 8'h01) begin
          next_s.pin.ce_n = 1'b0;
          next_s.pin.oe_n = 1'b0;
        end else if (s.ph == 8'(PLS_CYC + 1)) begin
          next_s.pin.ce_n = 1'b1;
          next_s.pin.oe_n = 1'b1;
          next_s.prevp    = MEM_DQ_IN;
          next_s.st       = PGEE_CHK;
        end
      end
      PGEE_CHK: begin
        next_s.ph = 8'h00;
        // true bit 7 and stable flip bit mean done
        if (!s.first && (s.prevp[`PGEE_POLL_BIT] == s.wdat[`PGEE_POLL_BIT] || !s.last_w) &&
            s.prevp[`PGEE_FLIP_BIT] == s.rsp.data[`PGEE_FLIP_BIT]) begin
          next_s.st = PGEE_IDLE;
          next_s.pin.id_hv = 1'b0;
          next_s.rsp.done = 1'b1;
        end else if (t_zero) begin
          next_s.st = PGEE_IDLE;
          next_s.pin.id_hv = 1'b0;
          next_s.rsp.timeout = 1'b1;
        end else begin
          next_s.st = PGEE_POLL;
        end
        next_s.rsp.data = s.prevp;
        next_s.first    = 1'b0;
        next_s.last_w = (next_s.st == PGEE_IDLE) ? 1'b0 : s.last_w;
      end
      default: begin
        next_s.st = PGEE_IDLE;
      end
    endcase
  end
  // register all state; guard state lives in the device
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s       <= '0;
      s.st    <= PGEE_PWRUP;
      s.first <= 1'b1;
      s.pre   <= 2'h3;
      s.pin   <= '{1'b1, 1'b1, 1'b1, 1'b0, 17'h00000, 8'h00, 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign REQ_READY   = s.rdy;
  assign RSP_DONE    = s.rsp.done;
  assign RSP_TIMEOUT = s.rsp.timeout;
  assign RSP_DATA    = s.rsp.data;
  assign MEM_CE_N    = s.pin.ce_n;
  assign MEM_OE_N    = s.pin.oe_n;
  assign MEM_WE_N    = s.pin.we_n;
  assign MEM_ID_HV   = s.pin.id_hv;
  assign MEM_ADDR    = s.pin.addr;
  assign MEM_DQ_OUT  = s.pin.dq_out;
  assign MEM_DQ_OE   = s.pin.dq_oe;
endmodule
`default_nettype wire

// ---- verification/pgee_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pgee_consts.svh"
// behavioural paged memory seen by the host
module pgee_mem_model
  import pgee_pkg::*;
#(
  parameter int BLC  = 30,
  parameter int BUSY = 60
) (
  // clock
  input  wire logic        clk,
  // pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        id_hv,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout
);
  logic [7:0]  arr [logic [17:0]]; // array plus id area
  logic [7:0]  pg [int];           // page load buffer
  logic [17:0] la;                 // latched address
  logic [17:0] k;                  // read key
  logic [16:0] ca [3];             // command addresses
  logic [7:0]  cd [3];             // command data
  logic [7:0]  lastd = 8'h00;      // last byte loaded
  logic        tog = 1'b0;         // flip bit state
  logic        guard = 1'b0;       // write guard, kept until disabled
  logic        dis = 1'b0;         // last sequence was the disable one
  logic        armed = 1'b0;       // strobe fall seen with output enable high
  wire logic   strobe_n;           // low while both enables are low
  int          seq = 0;            // command bytes matched
  int          blc = 0;            // load timer
  int          busy = 0;           // programming timer
  initial begin
    dout = 8'h00;
    ca = '{`PGEE_CMD_A0, `PGEE_CMD_A1, `PGEE_CMD_A2};
    cd = '{`PGEE_CMD_D0, `PGEE_CMD_D1, `PGEE_CMD_EN};
  end
  // combined strobe: later fall and earlier rise of the two enables
  assign strobe_n = we_n | ce_n;
  // address on the write strobe fall
  always @(negedge strobe_n) begin
    if (oe_n) begin
      la = {id_hv, addr};
      armed = 1'b1;
    end
  end
  // data on the write strobe rise, commands dropped
  always @(posedge strobe_n) begin
    if (armed && oe_n && busy == 0) begin
      if (seq < 3 && la == {1'b0, ca[seq]} &&
          (din == cd[seq] || (seq == 2 && din == `PGEE_CMD_DIS))) begin
        dis = (seq == 2) && (din == `PGEE_CMD_DIS);
        seq++;
      end else begin
        pg[la[6:0]] = din;
        lastd = din;
      end
      blc = BLC;
    end
    armed = 1'b0;
  end
  // flip bit turns over on each status read
  always @(negedge oe_n) if (blc > 0 || busy > 0) tog = ~tog;
  // read path and internal timers
  always @(posedge clk) begin
    k = {id_hv, addr};
    if (ce_n || oe_n || !we_n) dout <= ~dout;
    else if (blc > 0 || busy > 0) dout <= {~lastd[7], tog, lastd[5:0]};
    else dout <= arr.exists(k) ? arr[k] : 8'hFF;
    if (blc > 0) begin
      blc = blc - 1;
      if (blc == 0) begin
        if (!guard || seq == 3) foreach (pg[i]) arr[{la[17:7], i[6:0]}] = pg[i];
        if (seq == 3) guard = !dis;
        pg.delete();
        seq = 0;
        dis = 1'b0;
        busy = BUSY;
      end
    end else if (busy > 0) busy = busy - 1;
  end
endmodule
`default_nettype wire

// ---- verification/pgee_host_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// pin protocol checks on the host
module pgee_host_checker
  import pgee_pkg::*;
#(
  parameter int PON_CYC = 50
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // watched ports
  input  wire logic        REQ_READY,
  input  wire logic        MEM_CE_N,
  input  wire logic        MEM_OE_N,
  input  wire logic        MEM_WE_N,
  input  wire logic        MEM_ID_HV,
  input  wire logic [16:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_DQ_OUT,
  input  wire logic        MEM_DQ_OE
);
  int cnt; // cycles since reset release
  // count up to the power-on delay
  always_ff @(posedge CORE_CLK) begin
    if (RST) cnt <= 0;
    else if (cnt < PON_CYC) cnt <= cnt + 1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  AST_READ_PINS: assert property (!MEM_OE_N |-> MEM_WE_N && !MEM_CE_N)
    else $error("read strobe with write enable low");
  AST_NO_FIGHT: assert property (!MEM_OE_N |-> !MEM_DQ_OE)
    else $error("host drives data during read");
  AST_WRITE_PINS: assert property (!MEM_WE_N |-> MEM_OE_N && !MEM_CE_N && MEM_DQ_OE)
    else $error("write strobe without proper enables");
  AST_PULSE_WIDTH: assert property ($fell(MEM_WE_N) |-> !MEM_WE_N [*3])
    else $error("write pulse too short");
  AST_ADDR_HELD: assert property (!MEM_WE_N |-> $stable(MEM_ADDR) && $stable(MEM_DQ_OUT))
    else $error("address or data moved during strobe");
  AST_DATA_AT_RISE: assert property ($rose(MEM_WE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_OUT))
    else $error("data released before strobe end");
  AST_POWER_ON: assert property (cnt < PON_CYC - 1 |-> !REQ_READY && MEM_WE_N)
    else $error("access before power-on delay");
  AST_RESET_IDLE: assert property ($fell(RST) |-> MEM_CE_N && MEM_WE_N && !MEM_DQ_OE)
    else $error("pins not idle after reset");
  AST_ID_RANGE: assert property (MEM_ID_HV && !MEM_CE_N |-> MEM_ADDR[16:7] == 10'h3FF)
    else $error("id access outside id range");
  CV_WRITE: cover property ($fell(MEM_WE_N));
  CV_READ: cover property ($fell(MEM_OE_N));
  CV_ID_WRITE: cover property (MEM_ID_HV && !MEM_WE_N);
endmodule
bind pgee_host pgee_host_checker #(.PON_CYC(PON_CYC)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .REQ_READY(REQ_READY), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
  .MEM_ID_HV(MEM_ID_HV), .MEM_ADDR(MEM_ADDR), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE));
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the host
module tb
  import pgee_pkg::*;
;
  logic        CORE_CLK = 0;
  logic        RST = 1;
  logic        v = 0, w = 0, l = 0, id = 0, pf = 0, gd = 0;
  logic [16:0] a = 17'h00000;
  logic [7:0]  d = 8'h00, r = 8'h51;
  wire logic   rdy, done, tmo, ce, oe, we, hv, dqoe;
  wire logic [7:0]  rdata, dqo, dqi;
  wire logic [16:0] ma;
  logic [8:0]  expq [$];            // read flag and data
  logic [8:0]  e;
  logic [7:0]  pd [4];
  int          off [4] = '{5, 1, 5, 7};
  int          miscompares = 0, checks = 0;
  // 25 MHz clock
  initial forever #20 CORE_CLK = ~CORE_CLK;
  pgee_host #(.PON_CYC(50), .WC_CYC(400), .GAP_CYC(20)) dut (.CORE_CLK(CORE_CLK), .RST(RST),
    .REQ_VALID(v), .REQ_WRITE(w), .REQ_LAST(l), .REQ_ID(id), .REQ_ADDR(a), .REQ_DATA(d),
    .GUARD_PREFIX(pf), .GUARD_DISABLE(gd), .REQ_READY(rdy), .RSP_DONE(done),
    .RSP_TIMEOUT(tmo), .RSP_DATA(rdata), .MEM_CE_N(ce), .MEM_OE_N(oe), .MEM_WE_N(we),
    .MEM_ID_HV(hv), .MEM_ADDR(ma), .MEM_DQ_OUT(dqo), .MEM_DQ_OE(dqoe), .MEM_DQ_IN(dqi));
  pgee_mem_model u_mem (.clk(CORE_CLK), .ce_n(ce), .oe_n(oe), .we_n(we), .id_hv(hv),
    .addr(ma), .din(dqo), .dout(dqi));
  // pseudo random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one request, noted in the queue
  task automatic req(input logic wr, ls, ix, pfx, input logic [16:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    v <= 1'b1; w <= wr; l <= ls; id <= ix; pf <= pfx; a <= ad; d <= dt;
    expq.push_back({~wr, dt});
    // a last byte answers once when loaded and once when polling ends
    if (wr && ls) expq.push_back(9'h000);
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (rdy !== 1'b1 && n < 2000);
    if (rdy !== 1'b1) begin
      miscompares++;
      $display("unexpected ready expected 1 seen %b", rdy);
      close_out();
    end else begin
      v <= 1'b0;
    end
  endtask
  // wait until every noted answer has come
  task automatic drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 2000) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (expq.size() != 0) begin
      miscompares++;
      $display("unexpected answers left expected 0 seen %0d", expq.size());
    end
  endtask
  // each done answer takes the oldest note; a timeout or an answer with no note left counts as a miscompare
  always @(posedge CORE_CLK) begin
    if (!RST && (done === 1'b1 || tmo === 1'b1)) begin
      checks++;
      if (tmo === 1'b1 || expq.size() == 0) begin
        miscompares++;
        $display("unexpected answer expected done seen timeout or extra");
      end else begin
        e = expq.pop_front();
        if (e[8] && rdata !== e[7:0]) begin
          miscompares++;
          $display("unexpected read data expected %h seen %h", e[7:0], rdata);
        end
      end
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      pd[i] = r;
      req(1, i == 3, 0, 0, 17'h00480 + 17'(off[i]), r);
    end
    req(0, 0, 0, 0, 17'h00485, pd[2]);
    req(0, 0, 0, 0, 17'h00481, pd[1]);
    req(0, 0, 0, 0, 17'h00487, pd[3]);
    req(0, 0, 0, 0, 17'h00482, 8'hFF);
    r = lfsr(r);
    req(1, 1, 1, 0, 17'h1FF83, r);
    req(0, 0, 1, 0, 17'h1FF83, r);
    req(0, 0, 0, 0, 17'h1FF83, 8'hFF);
    r = lfsr(r);
    req(1, 0, 0, 0, 17'h00500, r);
    expq.push_back(9'h000);
    drain();
    req(0, 0, 0, 0, 17'h00500, r);
    r = lfsr(r);
    req(1, 1, 0, 1, 17'h00600, r);
    req(0, 0, 0, 0, 17'h00600, r);
    req(0, 0, 0, 0, 17'h05555, 8'hFF);
    req(1, 1, 0, 0, 17'h00600, r ^ 8'h01);
    req(0, 0, 0, 0, 17'h00600, r);
    gd <= 1'b1;
    req(1, 1, 0, 0, 17'h00600, r);
    gd <= 1'b0;
    drain();
    req(1, 1, 0, 0, 17'h00600, r ^ 8'h02);
    req(0, 0, 0, 0, 17'h00600, r ^ 8'h02);
    drain();
    close_out();
  end
endmodule
`default_nettype wire
